// ===== rcs_consts.svh
`ifndef RCS_CONSTS_SVH
`define RCS_CONSTS_SVH

// ==========================================================================
// Register byte offsets
`define RCS_OFS_FREQ_CMD      12'h000
`define RCS_OFS_FREQ_SRC      12'h004
`define RCS_OFS_STEP_BASE     12'h008
`define RCS_OFS_IN_FUNC_BASE  12'h024
`define RCS_OFS_RUN_SRC       12'h038
`define RCS_OFS_KEY_DIR       12'h03c
`define RCS_OFS_DIR_INHIBIT   12'h040
`define RCS_OFS_AUTO_START    12'h044
`define RCS_OFS_STATUS        12'h048

// ==========================================================================
// Reset values
`define RCS_RST_FREQ_SRC      4'h0
`define RCS_RST_RUN_SRC       2'h1
`define RCS_RST_DIR_INHIBIT   2'h0
`define RCS_RST_FREQ          16'h0000

// ==========================================================================
// Terminal function codes
`define RCS_FN_FWD_RUN        5'h00
`define RCS_FN_REV_RUN        5'h01
`define RCS_FN_STEP_B0        5'h05
`define RCS_FN_STEP_B1        5'h06
`define RCS_FN_STEP_B2        5'h07

// ==========================================================================
// Field positions and counts
`define RCS_AUTO_POWERON_BIT  0
`define RCS_AUTO_FAULT_BIT    1
`define RCS_NUM_TERMINALS     5
`define RCS_NUM_STEPS         7

`endif

// ===== rcs_partner.sv
`timescale 1ns/1ps
// ==========================================================================
// Keypad keys and terminal contacts
module rcs_partner #(
  parameter int PRESS = 10
) (
  input  wire logic       pclk,
  input  wire logic       run_req,
  input  wire logic       stop_req,
  input  wire logic [4:0] term_req,
  output logic            key_run,
  output logic            key_stop,
  output logic [4:0]      input_terminals
);
  int run_cnt = 0;
  int stop_cnt = 0;

  // A key press is a contact held for PRESS cycles
  always_ff @(posedge pclk) begin
    run_cnt <= run_req ? PRESS : (run_cnt > 0 ? run_cnt - 1 : 0);
    stop_cnt <= stop_req ? PRESS : (stop_cnt > 0 ? stop_cnt - 1 : 0);
  end
  assign key_run = run_cnt != 0;
  assign key_stop = stop_cnt != 0;
  assign input_terminals = term_req;
endmodule

// ===== rcs_pkg.sv
package rcs_pkg;

  typedef enum logic [1:0] {
    RCS_SRC_KEYPAD   = 2'h0,
    RCS_SRC_TWO_WIRE = 2'h1,
    RCS_SRC_RUN_DIR  = 2'h2
  } rcs_run_src_t;

  typedef enum logic [1:0] {
    RCS_INH_NONE = 2'h0,
    RCS_INH_FWD  = 2'h1,
    RCS_INH_REV  = 2'h2
  } rcs_inhibit_t;

  typedef enum logic [2:0] {
    RCS_ST_STOP = 3'b001,
    RCS_ST_ARM  = 3'b010,
    RCS_ST_RUN  = 3'b100
  } rcs_state_t;

  typedef struct packed {
    logic        run;
    logic        reverse;
    logic [15:0] target_freq;
  } rcs_cmd_t;

endpackage

// ===== rcs_run_command.sv
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "rcs_consts.svh"

module rcs_run_command #(
  parameter int FREQ_W = 16
) (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [11:0]                paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic                       key_run,
  input  wire logic                       key_stop,
  input  wire logic [4:0]                 input_terminals,
  input  wire logic                       fault_active,
  input  wire logic [FREQ_W-1:0]          source_freq,
  output rcs_pkg::rcs_cmd_t               drive_cmd,
  output logic      [3:0]                 freq_source_sel
);

  // ==========================================================================
  // Input synchronisers
  logic [4:0] term_meta_q;
  logic [4:0] term_q;
  logic [2:0] keys_meta_q;
  logic [2:0] keys_q;
  logic [2:0] keys_prev_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      term_meta_q <= 5'h00;
      term_q      <= 5'h00;
      keys_meta_q <= 3'h0;
      keys_q      <= 3'h0;
      keys_prev_q <= 3'h0;
    end else begin
      term_meta_q <= input_terminals;
      term_q      <= term_meta_q;
      keys_meta_q <= {fault_active, key_stop, key_run};
      keys_q      <= keys_meta_q;
      keys_prev_q <= keys_q;
    end
  end

  logic run_key_press;
  logic stop_key_press;
  logic fault_cleared;
  assign run_key_press  = keys_q[0] & ~keys_prev_q[0];
  assign stop_key_press = keys_q[1] & ~keys_prev_q[1];
  assign fault_cleared  = ~keys_q[2] & keys_prev_q[2];

  // ==========================================================================
  // Registers
  logic [FREQ_W-1:0] freq_cmd_q;
  logic [3:0]        freq_src_q;
  logic [FREQ_W-1:0] step_freq_q [1:`RCS_NUM_STEPS];
  logic [4:0]        in_func_q   [0:`RCS_NUM_TERMINALS-1];
  logic [1:0]        run_src_q;
  logic              key_dir_q;
  logic [1:0]        inhibit_q;
  logic              pwr_start_en_q;
  logic              fault_restart_en_q;

  logic wr_en;
  assign wr_en   = psel & penable & pwrite;
  assign pready  = 1'b1;

  logic addr_hit;
  always_comb begin
    addr_hit = (paddr[1:0] == 2'h0) && (paddr <= `RCS_OFS_STATUS);
  end
  assign pslverr = psel & penable & ~addr_hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      freq_cmd_q         <= FREQ_W'(`RCS_RST_FREQ);
      freq_src_q         <= `RCS_RST_FREQ_SRC;
      run_src_q          <= `RCS_RST_RUN_SRC;
      key_dir_q          <= 1'b0;
      inhibit_q          <= `RCS_RST_DIR_INHIBIT;
      pwr_start_en_q     <= 1'b0;
      fault_restart_en_q <= 1'b0;
    end else if (wr_en) begin
      unique case (paddr)
        `RCS_OFS_FREQ_CMD:    freq_cmd_q <= pwdata[FREQ_W-1:0];
        `RCS_OFS_FREQ_SRC:    freq_src_q <= pwdata[3:0];
        `RCS_OFS_RUN_SRC:     run_src_q  <= pwdata[1:0];
        `RCS_OFS_KEY_DIR:     key_dir_q  <= pwdata[0];
        `RCS_OFS_DIR_INHIBIT: inhibit_q  <= pwdata[1:0];
        `RCS_OFS_AUTO_START: begin
          pwr_start_en_q     <= pwdata[`RCS_AUTO_POWERON_BIT];
          fault_restart_en_q <= pwdata[`RCS_AUTO_FAULT_BIT];
        end
        default: ;
      endcase
    end
  end

  // Step tables and terminal functions, one word each
  genvar gi;
  generate
    for (gi = 1; gi <= `RCS_NUM_STEPS; gi++) begin : g_step
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          step_freq_q[gi] <= FREQ_W'(`RCS_RST_FREQ);
        end else if (wr_en && paddr == `RCS_OFS_STEP_BASE + 12'(4 * (gi - 1))) begin
          step_freq_q[gi] <= pwdata[FREQ_W-1:0];
        end
      end
    end
    for (gi = 0; gi < `RCS_NUM_TERMINALS; gi++) begin : g_func
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          in_func_q[gi] <= 5'(gi);
        end else if (wr_en && paddr == `RCS_OFS_IN_FUNC_BASE + 12'(4 * gi)) begin
          in_func_q[gi] <= pwdata[4:0];
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Terminal decode
  logic       fwd_in;
  logic       rev_in;
  logic [2:0] step_idx;

  always_comb begin
    fwd_in = term_q[0] & (in_func_q[0] == `RCS_FN_FWD_RUN);
    rev_in = term_q[1] & (in_func_q[1] == `RCS_FN_REV_RUN);
    step_idx = {term_q[4] & (in_func_q[4] == `RCS_FN_STEP_B2),
                term_q[3] & (in_func_q[3] == `RCS_FN_STEP_B1),
                term_q[2] & (in_func_q[2] == `RCS_FN_STEP_B0)};
  end

  // Terminal request and direction for the selected source
  logic term_req;
  logic term_rev;
  always_comb begin
    term_req = 1'b0;
    term_rev = 1'b0;
    unique case (run_src_q)
      rcs_pkg::RCS_SRC_TWO_WIRE: begin
        term_req = fwd_in ^ rev_in;
        term_rev = rev_in;
      end
      rcs_pkg::RCS_SRC_RUN_DIR: begin
        term_req = fwd_in;
        term_rev = rev_in;
      end
      default: ;
    endcase
  end

  // ==========================================================================
  // Run state
  rcs_pkg::rcs_state_t state_q;
  logic [1:0]          settle_q;
  logic                settled;
  logic                pwr_up_q;
  logic                keypad_src;
  assign keypad_src = (run_src_q == rcs_pkg::RCS_SRC_KEYPAD);
  assign settled    = (settle_q == 2'h2);

  // Terminals are only trusted once the synchronisers hold real samples
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_q <= 2'h0;
    end else if (!settled) begin
      settle_q <= settle_q + 2'h1;
    end
  end

  // Power-up arming lasts until the first run, stop or fault
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_up_q <= 1'b1;
    end else if (keys_q[2] || state_q != rcs_pkg::RCS_ST_ARM) begin
      pwr_up_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= rcs_pkg::RCS_ST_ARM;
    end else if (keys_q[2]) begin
      state_q <= rcs_pkg::RCS_ST_ARM;
    end else if (keypad_src) begin
      if (stop_key_press) begin
        state_q <= rcs_pkg::RCS_ST_STOP;
      end else if (run_key_press) begin
        state_q <= rcs_pkg::RCS_ST_RUN;
      end else if (state_q == rcs_pkg::RCS_ST_ARM) begin
        state_q <= rcs_pkg::RCS_ST_STOP;
      end
    end else begin
      unique case (state_q)
        rcs_pkg::RCS_ST_STOP: begin
          if (term_req) begin
            state_q <= rcs_pkg::RCS_ST_RUN;
          end
        end
        rcs_pkg::RCS_ST_ARM: begin
          if (!settled) begin
            state_q <= rcs_pkg::RCS_ST_ARM;
          end else if (!term_req) begin
            state_q <= rcs_pkg::RCS_ST_STOP;
          end else if (pwr_up_q && pwr_start_en_q) begin
            state_q <= rcs_pkg::RCS_ST_RUN;
          end else if (fault_cleared && fault_restart_en_q) begin
            state_q <= rcs_pkg::RCS_ST_RUN;
          end
        end
        rcs_pkg::RCS_ST_RUN: begin
          if (!term_req) begin
            state_q <= rcs_pkg::RCS_ST_STOP;
          end
        end
        default: state_q <= rcs_pkg::RCS_ST_STOP;
      endcase
    end
  end

  // Power-up with a live terminal must not run unless enabled
  logic armed_at_reset_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_at_reset_q <= 1'b1;
    end else begin
      armed_at_reset_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Command output
  logic             run_now;
  logic             rev_now;
  logic [FREQ_W-1:0] step_freq;

  always_comb begin
    rev_now = keypad_src ? key_dir_q : term_rev;
    run_now = (state_q == rcs_pkg::RCS_ST_RUN) && !armed_at_reset_q;
    if (inhibit_q == rcs_pkg::RCS_INH_FWD && !rev_now) begin
      run_now = 1'b0;
    end
    if (inhibit_q == rcs_pkg::RCS_INH_REV && rev_now) begin
      run_now = 1'b0;
    end
    if (step_idx == 3'h0) begin
      step_freq = source_freq;
    end else begin
      step_freq = step_freq_q[step_idx];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_cmd <= '0;
    end else begin
      drive_cmd.run         <= run_now;
      drive_cmd.reverse     <= rev_now;
      drive_cmd.target_freq <= run_now ? step_freq : '0;
    end
  end

  assign freq_source_sel = freq_src_q;

  // ==========================================================================
  // Read mux
  always_comb begin
    prdata = 32'h0000_0000;
    if (psel && !pwrite) begin
      if (paddr == `RCS_OFS_FREQ_CMD) prdata[FREQ_W-1:0] = freq_cmd_q;
      if (paddr == `RCS_OFS_FREQ_SRC) prdata[3:0] = freq_src_q;
      for (int i = 1; i <= `RCS_NUM_STEPS; i++) begin
        if (paddr == `RCS_OFS_STEP_BASE + 12'(4 * (i - 1))) prdata[FREQ_W-1:0] = step_freq_q[i];
      end
      for (int i = 0; i < `RCS_NUM_TERMINALS; i++) begin
        if (paddr == `RCS_OFS_IN_FUNC_BASE + 12'(4 * i)) prdata[4:0] = in_func_q[i];
      end
      if (paddr == `RCS_OFS_RUN_SRC) prdata[1:0] = run_src_q;
      if (paddr == `RCS_OFS_KEY_DIR) prdata[0] = key_dir_q;
      if (paddr == `RCS_OFS_DIR_INHIBIT) prdata[1:0] = inhibit_q;
      if (paddr == `RCS_OFS_AUTO_START) prdata[1:0] = {fault_restart_en_q, pwr_start_en_q};
      if (paddr == `RCS_OFS_STATUS) prdata[22:0] = {step_idx, drive_cmd.run, drive_cmd.reverse,
                                                   state_q, term_q, 10'h000};
    end
  end

endmodule

// ===== rcs_run_command_assertions.sv
`timescale 1ns/1ps
// ==========================================================================
// Port checker
module rcs_run_command_assertions (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [11:0]       paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              key_stop,
  input wire rcs_pkg::rcs_cmd_t drive_cmd,
  input wire logic [3:0]        freq_source_sel
);
  wire       acc = psel && penable;
  wire       bad_a = paddr > 12'h048 || paddr[1:0] != 2'h0;
  logic [3:0] src_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Last value written to the frequency source register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_q <= 4'h0;
    end else if (acc && pwrite && paddr == 12'h004) begin
      src_q <= pwdata[3:0];
    end
  end

  sequence s_stop_held;
    key_stop [*8];
  endsequence
  sequence s_src_wr;
    acc && pwrite && paddr == 12'h004;
  endsequence

  AST_READY: assert property (acc |-> pready)
    else $error("access phase without ready");
  AST_SLVERR_BAD: assert property (acc && bad_a |-> pslverr)
    else $error("bad address not refused");
  AST_SLVERR_OK: assert property (acc && !bad_a |-> !pslverr)
    else $error("good address refused");
  AST_RD_BAD: assert property (acc && !pwrite && bad_a |-> prdata == 32'h0)
    else $error("bad address read not zero");
  AST_STOP_TGT: assert property (!drive_cmd.run |-> drive_cmd.target_freq == 16'h0)
    else $error("target set while stopped");
  AST_RESET_RUN: assert property ($rose(presetn) |-> !drive_cmd.run)
    else $error("run right after reset");
  AST_KEY_STOP: assert property (s_stop_held |-> !drive_cmd.run)
    else $error("run while stop key held");
  AST_FSRC: assert property (s_src_wr |-> ##2 freq_source_sel == src_q)
    else $error("frequency source copy stale");
endmodule

bind rcs_run_command rcs_run_command_assertions u_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .key_stop, .drive_cmd, .freq_source_sel
);

// ===== rcs_run_command_bench.sv
`timescale 1ns/1ps
module rcs_run_command_bench;
  logic              pclk = 1'b0;
  logic              presetn = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [11:0]       paddr = 12'h000;
  logic [31:0]       pwdata = 32'h0;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              key_run;
  logic              key_stop;
  logic              run_req = 1'b0;
  logic              stop_req = 1'b0;
  logic [4:0]        term_req = 5'h00;
  logic [4:0]        input_terminals;
  logic              fault_active = 1'b0;
  logic [15:0]       source_freq = 16'h0000;
  rcs_pkg::rcs_cmd_t drive_cmd;
  logic [3:0]        freq_source_sel;
  logic [31:0]       rd;
  logic [4:0]        t;
  logic              rsp;
  int                num_errors = 0;
  int                compares = 0;
  int                freq[8];
  int                i;
  int                src;
  int                inh;
  int                run;

  rcs_run_command u_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .key_run, .key_stop, .input_terminals,
    .fault_active, .source_freq, .drive_cmd, .freq_source_sel
  );
  rcs_partner u_keys (
    .pclk, .run_req, .stop_req, .term_req, .key_run, .key_stop, .input_terminals
  );

  initial forever #2.5 pclk = ~pclk;

  // ==========================================================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    rsp = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic finish_test();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    num_errors++;
    finish_test();
  end

  // ==========================================================================
  // Tests
  initial begin
    void'($urandom(12));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (i = 0; i < 5; i++) begin
      apb(1'b0, 12'(12'h024 + 4 * i), 32'h0);
      check(rd, i);
    end
    apb(1'b0, 12'h038, 32'h0);
    check(rd, 32'h1);
    apb(1'b0, 12'h04c, 32'h0);
    check(rd, 32'h0);
    check(rsp, 1'b1);
    $display("test register reset done");
    freq[0] = $urandom % 65536;
    source_freq <= 16'(freq[0]);
    apb(1'b1, 12'h000, freq[0]);
    src = $urandom % 16;
    apb(1'b1, 12'h004, src);
    check(freq_source_sel, src);
    for (i = 1; i < 8; i++) begin
      freq[i] = $urandom % 65536;
      apb(1'b1, 12'(4 + 4 * i), freq[i]);
    end
    for (i = 5; i < 8; i++) apb(1'b1, 12'(4 * i + 12'h018), i);
    for (i = 0; i < 60; i++) begin
      term_req <= 5'h00;
      src = 1 + $urandom % 2;
      inh = $urandom % 3;
      apb(1'b1, 12'h038, src);
      apb(1'b1, 12'h040, inh);
      t = 5'($urandom);
      term_req <= t;
      repeat (10) @(posedge pclk);
      run = (src == 1) ? (t[0] ^ t[1]) : t[0];
      if ((inh == 1 && !t[1]) || (inh == 2 && t[1])) run = 0;
      check(drive_cmd.run, run);
      check(drive_cmd.target_freq, run ? freq[t[4:2]] : 0);
      if (run) check(drive_cmd.reverse, t[1]);
    end
    $display("test terminal run done");
    term_req <= 5'h00;
    apb(1'b1, 12'h040, 32'h0);
    apb(1'b1, 12'h038, 32'h0);
    for (i = 0; i < 2; i++) begin
      apb(1'b1, 12'h03c, i);
      run_req <= 1'b1;
      @(posedge pclk);
      run_req <= 1'b0;
      repeat (14) @(posedge pclk);
      check(drive_cmd.run, 1);
      check(drive_cmd.reverse, i);
      check(drive_cmd.target_freq, freq[0]);
      stop_req <= 1'b1;
      @(posedge pclk);
      stop_req <= 1'b0;
      repeat (14) @(posedge pclk);
      check(drive_cmd.run, 0);
    end
    $display("test keypad done");
    apb(1'b1, 12'h038, 32'h1);
    for (i = 0; i < 2; i++) begin
      apb(1'b1, 12'h044, 2 * i);
      term_req <= 5'h01;
      repeat (10) @(posedge pclk);
      fault_active <= 1'b1;
      repeat (10) @(posedge pclk);
      fault_active <= 1'b0;
      repeat (10) @(posedge pclk);
      check(drive_cmd.run, i);
      term_req <= 5'h00;
      repeat (10) @(posedge pclk);
      term_req <= 5'h01;
      repeat (10) @(posedge pclk);
      check(drive_cmd.run, 1);
      term_req <= 5'h00;
    end
    $display("test fault restart done");
    term_req <= 5'h01;
    presetn <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (10) @(posedge pclk);
    check(drive_cmd.run, 0);
    apb(1'b1, 12'h044, 32'h1);
    repeat (10) @(posedge pclk);
    check(drive_cmd.run, 1);
    term_req <= 5'h00;
    repeat (10) @(posedge pclk);
    check(drive_cmd.run, 0);
    $display("test power-on start done");
    finish_test();
  end
endmodule
